// ### hdl/mabx_pkg.sv
// mabx_pkg: constants shared by the bit and arithmetic execution unit
// assumes a 14-bit instruction word and a 128-byte file register space
package mabx_pkg;

    // data path widths
    localparam int unsigned DATA_W = 8;
    localparam int unsigned FADDR_W = 7;
    localparam int unsigned INSTR_W = 14;
    localparam int unsigned BUS_AW = 8;
    localparam int unsigned FILE_DEPTH = 128;

    // opcode patterns, compared against the upper instruction bits
    localparam logic [5:0] OP_ADD_ACC_AND_FILE = 6'h07;  // bits 13:8
    localparam logic [5:0] OP_AND_ACC_WITH_FILE = 6'h05; // bits 13:8
    localparam logic [5:0] OP_ZERO_FILE_REG = 6'h01;     // bits 13:8, bit 7 set
    localparam logic [5:0] OP_AND_IMM_WITH_ACC = 6'h39;  // bits 13:8
    localparam logic [4:0] OP_ADD_IMM_TO_ACC = 5'h1F;    // bits 13:9
    localparam logic [3:0] OP_FILE_BIT_CLEAR = 4'h4;     // bits 13:10
    localparam logic [3:0] OP_FILE_BIT_SET = 4'h5;       // bits 13:10
    localparam logic [3:0] OP_TEST_SKIP_ZERO = 4'h6;     // bits 13:10
    localparam logic [3:0] OP_TEST_SKIP_ONE = 4'h7;      // bits 13:10

    // instruction field positions
    localparam int unsigned DEST_BIT = 7;
    localparam int unsigned BITPOS_LSB = 7;

    // register port map: 0x00..0x7F file space, then core registers
    localparam logic [BUS_AW-1:0] ADDR_ACC = 8'h80;
    localparam logic [BUS_AW-1:0] ADDR_STATUS = 8'h81;

    // file address that holds the i/o port latch
    localparam logic [FADDR_W-1:0] PORT_FADDR = 7'h05;

    // status register field positions
    localparam int unsigned ST_CARRY = 0;
    localparam int unsigned ST_HALF_CARRY = 1;
    localparam int unsigned ST_ZERO = 2;

    // reset values
    localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
    localparam logic [DATA_W-1:0] FILE_RST = 8'h00;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

endpackage : mabx_pkg

// ### hdl/mabx_adder.sv
// mabx_adder: 8-bit adder with carry, half carry and zero outputs
// assumes pure combinational use inside the execution unit
`timescale 1ns/10ps
`default_nettype none
module mabx_adder
(
    input wire logic [mabx_pkg::DATA_W-1:0] a_i,
    input wire logic [mabx_pkg::DATA_W-1:0] b_i,
    output logic [mabx_pkg::DATA_W-1:0] sum_o,
    output logic carry_o,
    output logic half_carry_o,
    output logic zero_o
);
    import mabx_pkg::*;

    logic [DATA_W:0] full_sum; // nine bits, top is carry out
    logic [4:0] low_sum; // low nibble plus its carry

    // sums are computed one bit wider so no carry is lost
    always_comb
    begin
        full_sum = {1'b0, a_i} + {1'b0, b_i};
        low_sum = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]};
        sum_o = full_sum[DATA_W-1:0];
        carry_o = full_sum[DATA_W];
        half_carry_o = low_sum[4];
        zero_o = (full_sum[DATA_W-1:0] == ZERO_BYTE);
    end

endmodule : mabx_adder
`default_nettype wire

// ### hdl/mabx_exec.sv
// mabx_exec: execution unit for add, and, clear, bit set/clear, bit test/skip
// assumes instructions arrive one per cycle from a fetch stage on clk_i and
// that the pin inputs are asynchronous to clk_i
//
// Summary of operation
// - add immediate to accumulator, update all flags
// - add accumulator and file, update all flags
// - destination bit zero accumulator, one file
// - and accumulator with file, zero flag only
// - and immediate with accumulator, zero flag only
// - clear selected file bit, flags untouched
// - set selected file bit, flags untouched
// - skip next instruction when tested bit zero
// - skip next instruction when tested bit one
// - clear file register and set zero flag
// - one cycle, two when skip taken
// - port read-modify-write uses pin levels
`timescale 1ns/10ps
`default_nettype none
module mabx_exec
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    // instruction stream
    input wire logic instr_valid_i,
    input wire logic [mabx_pkg::INSTR_W-1:0] instr_i,
    // i/o port pins and output latch
    input wire logic [mabx_pkg::DATA_W-1:0] port_pins_i,
    output logic [mabx_pkg::DATA_W-1:0] port_latch_o,
    // register port
    input wire logic [mabx_pkg::BUS_AW-1:0] reg_addr_i,
    input wire logic [mabx_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [mabx_pkg::DATA_W-1:0] reg_rdata_o,
    // core state
    output logic [mabx_pkg::DATA_W-1:0] acc_o,
    output logic carry_flag_o,
    output logic half_carry_flag_o,
    output logic zero_flag_o,
    output logic no_operation_slot_o,
    output logic done_o
);
    import mabx_pkg::*;

    logic [DATA_W-1:0] file_r [0:FILE_DEPTH-1]; // file register space
    logic [DATA_W-1:0] acc_r; // accumulator
    logic carry_r; // carry flag
    logic half_carry_flag_r; // half carry flag
    logic zero_r; // zero flag
    logic skip_r; // next slot is a discarded instruction
    logic done_r; // one pulse per executed instruction
    logic [DATA_W-1:0] rdata_r; // read data, one cycle after strobe
    logic [DATA_W-1:0] pin_meta_r; // first synchroniser stage
    logic [DATA_W-1:0] pin_sync_r; // second synchroniser stage

    // decoded fields
    logic [FADDR_W-1:0] faddr; // file operand address
    logic [2:0] bit_pos; // bit position operand
    logic dest_file; // destination is the file register
    logic [DATA_W-1:0] imm; // 8-bit immediate
    logic [DATA_W-1:0] file_src; // file operand as read
    logic take; // instruction is executed this cycle

    // decoded operations
    logic is_add_immediate; // add immediate to accumulator
    logic is_add_file; // add accumulator and file
    logic is_and_immediate; // and immediate with accumulator
    logic is_and_file; // and accumulator with file
    logic is_zero_file; // clear file register
    logic is_bit_clear; // clear one file bit
    logic is_bit_set; // set one file bit
    logic is_test_zero; // test bit, skip when zero
    logic is_test_one; // test bit, skip when one

    // adder operands and results
    logic [DATA_W-1:0] add_b;
    logic [DATA_W-1:0] add_sum;
    logic add_c;
    logic add_hc;
    logic add_z;

    // next values from the instruction path
    logic [DATA_W-1:0] result_nxt; // value of the operation
    logic acc_we; // result goes to accumulator
    logic file_we; // result goes to file register
    logic flags_all_we; // carry, half carry and zero update
    logic zero_we; // zero flag update only
    logic zero_nxt; // zero flag value
    logic skip_nxt; // skip condition met
    logic tested_bit; // bit under test

    // field extraction
    always_comb
    begin
        faddr = instr_i[FADDR_W-1:0];
        bit_pos = instr_i[BITPOS_LSB+2:BITPOS_LSB];
        dest_file = instr_i[DEST_BIT];
        imm = instr_i[DATA_W-1:0];
    end

    // an instruction presented in the slot after a taken skip is discarded
    always_comb
    begin
        take = instr_valid_i && !skip_r;
    end

    // opcode decode, only valid while take is high
    always_comb
    begin
        is_add_immediate = take && (instr_i[13:9] == OP_ADD_IMM_TO_ACC);
        is_add_file = take && (instr_i[13:8] == OP_ADD_ACC_AND_FILE);
        is_and_immediate = take && (instr_i[13:8] == OP_AND_IMM_WITH_ACC);
        is_and_file = take && (instr_i[13:8] == OP_AND_ACC_WITH_FILE);
        is_zero_file = take && (instr_i[13:8] == OP_ZERO_FILE_REG) && instr_i[DEST_BIT];
        is_bit_clear = take && (instr_i[13:10] == OP_FILE_BIT_CLEAR);
        is_bit_set = take && (instr_i[13:10] == OP_FILE_BIT_SET);
        is_test_zero = take && (instr_i[13:10] == OP_TEST_SKIP_ZERO);
        is_test_one = take && (instr_i[13:10] == OP_TEST_SKIP_ONE);
    end

    // the port address reads the synchronised pins, not the latch, so an input pin
    // pulled low by the outside is written back low
    always_comb
    begin
        if (faddr == PORT_FADDR)
        begin
            file_src = pin_sync_r;
        end
        else
        begin
            file_src = file_r[faddr];
        end
    end

    // one shared adder for both add forms
    always_comb
    begin
        add_b = is_add_immediate ? imm : file_src;
    end

    mabx_adder u_adder
    (
        .a_i(acc_r),
        .b_i(add_b),
        .sum_o(add_sum),
        .carry_o(add_c),
        .half_carry_o(add_hc),
        .zero_o(add_z)
    );

    // result, destination and flag selection
    always_comb
    begin
        result_nxt = ZERO_BYTE;
        acc_we = 1'b0;
        file_we = 1'b0;
        flags_all_we = 1'b0;
        zero_we = 1'b0;
        zero_nxt = 1'b0;
        skip_nxt = 1'b0;
        tested_bit = file_src[bit_pos];
        if (is_add_immediate)
        begin
            result_nxt = add_sum;
            acc_we = 1'b1;
            flags_all_we = 1'b1;
        end
        else if (is_add_file)
        begin
            result_nxt = add_sum;
            acc_we = !dest_file;
            file_we = dest_file;
            flags_all_we = 1'b1;
        end
        else if (is_and_file)
        begin
            result_nxt = acc_r & file_src;
            acc_we = !dest_file;
            file_we = dest_file;
            zero_we = 1'b1;
            zero_nxt = (result_nxt == ZERO_BYTE);
        end
        else if (is_and_immediate)
        begin
            result_nxt = acc_r & imm;
            acc_we = 1'b1;
            zero_we = 1'b1;
            zero_nxt = (result_nxt == ZERO_BYTE);
        end
        else if (is_zero_file)
        begin
            result_nxt = ZERO_BYTE;
            file_we = 1'b1;
            zero_we = 1'b1;
            zero_nxt = 1'b1;
        end
        else if (is_bit_clear)
        begin
            result_nxt = file_src;
            result_nxt[bit_pos] = 1'b0;
            file_we = 1'b1;
        end
        else if (is_bit_set)
        begin
            result_nxt = file_src;
            result_nxt[bit_pos] = 1'b1;
            file_we = 1'b1;
        end
        else if (is_test_zero)
        begin
            skip_nxt = !tested_bit;
        end
        else if (is_test_one)
        begin
            skip_nxt = tested_bit;
        end
        else
        begin
            // unsupported or no instruction: nothing changes
            result_nxt = ZERO_BYTE;
        end
    end

    // pin synchroniser, two stages before any logic reads the pins
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            pin_meta_r <= ZERO_BYTE;
            pin_sync_r <= ZERO_BYTE;
        end
        else
        begin
            pin_meta_r <= port_pins_i;
            pin_sync_r <= pin_meta_r;
        end
    end

    // file register space; a port write to the same address as an
    // instruction write lands last and wins
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            for (int i = 0; i < FILE_DEPTH; i++)
            begin
                file_r[i] <= FILE_RST;
            end
        end
        else
        begin
            if (file_we)
            begin
                file_r[faddr] <= result_nxt;
            end
            if (reg_wr_i && !reg_addr_i[BUS_AW-1])
            begin
                file_r[reg_addr_i[FADDR_W-1:0]] <= reg_wdata_i;
            end
        end
    end

    // accumulator, software write has priority over the instruction
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            acc_r <= ACC_RST;
        end
        else if (reg_wr_i && (reg_addr_i == ADDR_ACC))
        begin
            acc_r <= reg_wdata_i;
        end
        else if (acc_we)
        begin
            acc_r <= result_nxt;
        end
    end

    // status flags; bit ops and tests leave them alone
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            carry_r <= 1'b0;
            half_carry_flag_r <= 1'b0;
            zero_r <= 1'b0;
        end
        else if (reg_wr_i && (reg_addr_i == ADDR_STATUS))
        begin
            carry_r <= reg_wdata_i[ST_CARRY];
            half_carry_flag_r <= reg_wdata_i[ST_HALF_CARRY];
            zero_r <= reg_wdata_i[ST_ZERO];
        end
        else if (flags_all_we)
        begin
            carry_r <= add_c;
            half_carry_flag_r <= add_hc;
            zero_r <= add_z;
        end
        else if (zero_we)
        begin
            zero_r <= zero_nxt;
        end
    end

    // skip slot: the following cycle runs as a no-operation
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            skip_r <= 1'b0;
        end
        else
        begin
            skip_r <= skip_nxt;
        end
    end

    // completion pulse, one per executed instruction
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            done_r <= 1'b0;
        end
        else
        begin
            done_r <= take;
        end
    end

    // read data, valid only in the cycle after the read strobe
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rdata_r <= ZERO_BYTE;
        end
        else if (reg_rd_i)
        begin
            if (!reg_addr_i[BUS_AW-1])
            begin
                rdata_r <= file_r[reg_addr_i[FADDR_W-1:0]];
            end
            else if (reg_addr_i == ADDR_ACC)
            begin
                rdata_r <= acc_r;
            end
            else if (reg_addr_i == ADDR_STATUS)
            begin
                rdata_r <= {5'h00, zero_r, half_carry_flag_r, carry_r};
            end
            else
            begin
                rdata_r <= ZERO_BYTE; // unmapped reads as zero
            end
        end
        else
        begin
            rdata_r <= ZERO_BYTE;
        end
    end

    // outputs straight from flip-flops
    always_comb
    begin
        acc_o = acc_r;
        carry_flag_o = carry_r;
        half_carry_flag_o = half_carry_flag_r;
        zero_flag_o = zero_r;
        no_operation_slot_o = skip_r;
        done_o = done_r;
        reg_rdata_o = rdata_r;
        port_latch_o = file_r[PORT_FADDR];
    end

endmodule : mabx_exec
`default_nettype wire

// ### dv/mabx_exec_chk.sv
// mabx_exec_chk: port-level assertions for the execution unit
// assumes a bind onto mabx_exec, one clock, async active-low reset
`timescale 1ns/10ps
`default_nettype none
module mabx_exec_chk
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic instr_valid_i,
    input wire logic [mabx_pkg::INSTR_W-1:0] instr_i,
    input wire logic reg_wr_i,
    input wire logic [mabx_pkg::DATA_W-1:0] acc_o,
    input wire logic carry_flag_o,
    input wire logic half_carry_flag_o,
    input wire logic zero_flag_o,
    input wire logic no_operation_slot_o,
    input wire logic done_o
);
    import mabx_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    logic take; // accepted instruction, valid and not in a refused slot
    assign take = instr_valid_i && !no_operation_slot_o;
    // the refused slot after a taken skip
    sequence s_refuse;
        no_operation_slot_o ##1 (!done_o && !no_operation_slot_o);
    endsequence
    property p_addk;
        take && !reg_wr_i && instr_i[13:9] == 5'h1F
            |=> {carry_flag_o, acc_o} == {1'b0, $past(acc_o)} + $past(instr_i[7:0]);
    endproperty
    property p_half;
        take && !reg_wr_i && instr_i[13:9] == 5'h1F
            |=> half_carry_flag_o == (({1'b0, $past(acc_o[3:0])} + $past(instr_i[3:0])) > 5'h0F);
    endproperty
    property p_zero;
        take && !reg_wr_i && (instr_i[13:9] == 5'h1F || instr_i[13:8] == 6'h39)
            |=> zero_flag_o == (acc_o == 8'h00);
    endproperty
    property p_andk;
        take && !reg_wr_i && instr_i[13:8] == 6'h39
            |=> acc_o == ($past(acc_o) & $past(instr_i[7:0])) && $stable(carry_flag_o);
    endproperty
    property p_bitflags;
        take && !reg_wr_i && instr_i[13:12] == 2'b01
            |=> $stable({carry_flag_o, half_carry_flag_o, zero_flag_o, acc_o});
    endproperty
    property p_clrz;
        take && !reg_wr_i && instr_i[13:7] == 7'h03 |=> zero_flag_o && $stable(acc_o);
    endproperty
    property p_keepacc;
        take && !reg_wr_i && instr_i[7] && (instr_i[13:8] == 6'h07 || instr_i[13:8] == 6'h05)
            |=> $stable(acc_o);
    endproperty
    property p_done;
        take |=> done_o;
    endproperty
    property p_refuse;
        no_operation_slot_o |-> s_refuse;
    endproperty
    // a refused slot may only follow an accepted bit test
    property p_slot_cause;
        no_operation_slot_o |-> $past(take && instr_i[13:11] == 3'b011);
    endproperty
    a_addk: assert property (p_addk) else $error("add immediate sum or carry wrong");
    a_half: assert property (p_half) else $error("half carry wrong");
    a_zero: assert property (p_zero) else $error("zero flag wrong");
    a_andk: assert property (p_andk) else $error("and immediate wrong");
    a_bitflags: assert property (p_bitflags) else $error("bit op touched flags");
    a_clrz: assert property (p_clrz) else $error("clear did not set zero");
    a_keepacc: assert property (p_keepacc) else $error("file dest changed acc");
    a_done: assert property (p_done) else $error("done missing");
    a_refuse: assert property (p_refuse) else $error("slot not refused");
    a_slot_cause: assert property (p_slot_cause) else $error("test not finished");
endmodule : mabx_exec_chk
bind mabx_exec mabx_exec_chk u_chk (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i), .reg_wr_i(reg_wr_i), .acc_o(acc_o),
    .carry_flag_o(carry_flag_o), .half_carry_flag_o(half_carry_flag_o),
    .zero_flag_o(zero_flag_o), .no_operation_slot_o(no_operation_slot_o), .done_o(done_o));
`default_nettype wire

// ### dv/mcu_alu_bit_instr_exec_tb.sv
// mcu_alu_bit_instr_exec_tb: directed bench with a reference model of acc, flags, file
// assumes mabx_exec and the bound checker are compiled before it
`timescale 1ns/10ps
`default_nettype none
module mcu_alu_bit_instr_exec_tb;
    import mabx_pkg::*;
    logic clk_i, reset_n_i, instr_valid_i, reg_wr_i, reg_rd_i;
    logic [INSTR_W-1:0] instr_i;
    logic [DATA_W-1:0] port_pins_i, reg_wdata_i, port_latch_o, reg_rdata_o, acc_o;
    logic [BUS_AW-1:0] reg_addr_i;
    logic carry_flag_o, half_carry_flag_o, zero_flag_o, no_operation_slot_o, done_o;
    int error_cnt, comparisons;
    logic [7:0] mem [128]; // model file space
    logic [7:0] m_acc;
    logic m_c, m_hc, m_z, m_skip, m_done; // model flags and pending skip
    logic [7:0] kv [5] = '{8'h00, 8'hFF, 8'h01, 8'h0F, 8'h08}; // carry edge cases
    mabx_exec dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .instr_valid_i(instr_valid_i),
        .instr_i(instr_i), .port_pins_i(port_pins_i), .port_latch_o(port_latch_o),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .acc_o(acc_o),
        .carry_flag_o(carry_flag_o), .half_carry_flag_o(half_carry_flag_o),
        .zero_flag_o(zero_flag_o), .no_operation_slot_o(no_operation_slot_o), .done_o(done_o));
    initial
    begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    task test_done();
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : test_done
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // every cycle sets all request lines, so nothing lingers from the last call
    task drv(input logic v, input logic [13:0] w, input logic wr, input logic rd,
        input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        instr_valid_i <= v;
        instr_i <= w;
        reg_wr_i <= wr;
        reg_rd_i <= rd;
        reg_addr_i <= a;
        reg_wdata_i <= d;
    endtask : drv
    // {half carry, carry, sum}
    function automatic logic [9:0] addf(input logic [7:0] x, input logic [7:0] y);
        addf = {({1'b0, x[3:0]} + {1'b0, y[3:0]}) > 5'h0F, {1'b0, x} + {1'b0, y}};
    endfunction : addf
    // present one instruction and advance the model
    task ex(input logic [13:0] w);
        logic [7:0] f;
        logic [7:0] r;
        logic [6:0] a;
        drv(1'b1, w, 1'b0, 1'b0, 8'h00, 8'h00);
        a = w[6:0];
        f = (a == PORT_FADDR) ? port_pins_i : mem[a]; // port reads see pins
        m_done = !m_skip;
        r = 8'h00;
        if (m_skip)
            m_skip = 1'b0;
        else
            casez (w[13:8])
                6'b11111?: {m_hc, m_c, r} = addf(m_acc, w[7:0]);
                6'b111001: r = m_acc & w[7:0];
                6'b000111: {m_hc, m_c, r} = addf(m_acc, f);
                6'b000101: r = m_acc & f;
                6'b0100??: mem[a] = f & ~(8'h01 << w[9:7]);
                6'b0101??: mem[a] = f | (8'h01 << w[9:7]);
                6'b0110??: m_skip = !f[w[9:7]];
                6'b0111??: m_skip = f[w[9:7]];
                default: ;
            endcase
        if (m_done && w[13] == w[12])
            m_z = (r == 8'h00);
        if (m_done && w[13] == w[12] && (w[13] || !w[7]))
            m_acc = r;
        if (m_done && w[13:12] == 2'b00 && w[7])
            mem[a] = r;
    endtask : ex
    task wr(input logic [7:0] a, input logic [7:0] d);
        drv(1'b0, 14'h0000, 1'b1, 1'b0, a, d);
        if (a < 8'h80)
            mem[a[6:0]] = d;
        if (a == ADDR_ACC)
            m_acc = d;
        if (a == ADDR_STATUS)
            {m_z, m_hc, m_c} = d[2:0];
    endtask : wr
    task rd(input logic [7:0] a);
        logic [7:0] e;
        e = (a < 8'h80) ? mem[a[6:0]] : (a == ADDR_ACC) ? m_acc :
            (a == ADDR_STATUS) ? {5'h00, m_z, m_hc, m_c} : 8'h00;
        drv(1'b0, 14'h0000, 1'b0, 1'b1, a, 8'h00);
        drv(1'b0, 14'h0000, 1'b0, 1'b0, 8'h00, 8'h00);
        @(negedge clk_i);
        chk(reg_rdata_o, e);
        // read data stands one cycle only, then returns to zero
        drv(1'b0, 14'h0000, 1'b0, 1'b0, 8'h00, 8'h00);
        @(negedge clk_i);
        chk(reg_rdata_o, 8'h00);
    endtask : rd
    // one idle cycle, then compare all core state with the model
    task check();
        drv(1'b0, 14'h0000, 1'b0, 1'b0, 8'h00, 8'h00);
        @(negedge clk_i);
        chk(acc_o, m_acc);
        chk({5'h00, zero_flag_o, half_carry_flag_o, carry_flag_o}, {5'h00, m_z, m_hc, m_c});
        chk({6'h00, done_o, no_operation_slot_o}, {6'h00, m_done, m_skip});
        chk(port_latch_o, mem[PORT_FADDR]);
        m_done = 1'b0;
        m_skip = 1'b0;
    endtask : check
    initial
    begin
        #20000;
        error_cnt++;
        test_done();
    end
    initial
    begin
        {instr_valid_i, reg_wr_i, reg_rd_i, reset_n_i} = 4'h0;
        {instr_i, reg_addr_i, reg_wdata_i} = 30'h0;
        port_pins_i = 8'hA5; // differs from latch on purpose
        {m_acc, m_c, m_hc, m_z, m_skip, m_done} = 13'h0;
        foreach (mem[j]) mem[j] = 8'h00;
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1'b1;
        check();
        wr(8'h90, 8'hFF);
        rd(8'h90);
        rd(8'h10); // unmapped write must not leak into file space
        rd(ADDR_STATUS);
        foreach (kv[j])
        begin
            ex({6'h3E, kv[j]});
            check();
        end
        ex({6'h39, 8'hF0});
        check();
        ex({6'h39, 8'h0F});
        check();
        wr(ADDR_ACC, 8'h99);
        wr(8'h20, 8'h88);
        ex({6'h07, 1'b0, 7'h20});
        check();
        ex({6'h07, 1'b1, 7'h20});
        rd(8'h20);
        ex({6'h05, 1'b1, 7'h20});
        rd(8'h20);
        ex({6'h05, 1'b0, 7'h21});
        check();
        wr(ADDR_STATUS, 8'h00);
        ex({6'h01, 1'b1, 7'h20});
        check();
        rd(8'h20);
        wr(ADDR_STATUS, 8'h07);
        wr(8'h31, 8'hFF);
        for (int i = 0; i < 8; i++)
        begin
            ex({4'h5, 3'(i), 7'h30});
            ex({4'h4, 3'(i), 7'h31});
            check();
            rd(8'h31);
        end
        rd(8'h30);
        ex({4'h5, 3'd1, PORT_FADDR});
        rd(8'h05);
        for (int i = 0; i < 4; i++)
        begin
            ex({i[1] ? 4'h7 : 4'h6, 3'd2, i[0] ? 7'h30 : 7'h31});
            ex({6'h3E, 8'h01});
            ex({6'h3E, 8'h02});
            check();
        end
        ex({4'h7, 3'd0, 7'h30});
        check();
        test_done();
    end
endmodule : mcu_alu_bit_instr_exec_tb
`default_nettype wire
